/* clk_gate_pkg.sv */
package clk_gate_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Gating register sets, held as one array: index = 2 * mode + set
  localparam int NUM_GATE = 6;
  localparam int GATE_RUN1 = 0;
  localparam int GATE_RUN2 = 1;
  localparam int GATE_SLEEP1 = 2;
  localparam int GATE_SLEEP2 = 3;
  localparam int GATE_DEEP1 = 4;
  localparam int GATE_DEEP2 = 5;

  localparam logic [ADDR_W-1:0] OFF_RUN1   = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_RUN2   = 12'h108;
  localparam logic [ADDR_W-1:0] OFF_SLEEP1 = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_SLEEP2 = 12'h118;
  localparam logic [ADDR_W-1:0] OFF_DEEP1  = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_DEEP2  = 12'h128;
  localparam logic [ADDR_W-1:0] OFF_DSLP   = 12'h144;
  localparam logic [ADDR_W-1:0] OFF_FAULT  = 12'h150;
  localparam logic [ADDR_W-1:0] OFF_LDO    = 12'h160;

  localparam logic [ADDR_W-1:0] GATE_OFF [NUM_GATE] = '{
    OFF_RUN1, OFF_RUN2, OFF_SLEEP1, OFF_SLEEP2, OFF_DEEP1, OFF_DEEP2};

  // Implemented bits of each set; the rest is stored as zero
  localparam logic [DATA_W-1:0] SET1_MASK = 32'h0107_0013;
  localparam logic [DATA_W-1:0] SET2_MASK = 32'h0000_001f;
  localparam logic [DATA_W-1:0] GATE_MASK [NUM_GATE] = '{
    SET1_MASK, SET2_MASK, SET1_MASK, SET2_MASK, SET1_MASK, SET2_MASK};
  localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;

  // Single-bit control registers
  localparam int BIT_OSC_OVR = 0;
  localparam int BIT_FAULT_CLR = 0;
  localparam int BIT_LDO = 0;

  // Gated units: set (0 = set1, 1 = set2) and bit position
  localparam int NUM_UNITS = 12;
  localparam int UNIT_IDX_W = 4;
  localparam int U_SERIAL0 = 0;
  localparam int U_SERIAL1 = 1;
  localparam int U_SYNC_SERIAL = 2;
  localparam int U_TIMER0 = 3;
  localparam int U_TIMER1 = 4;
  localparam int U_TIMER2 = 5;
  localparam int U_COMPARATOR0 = 6;
  localparam int U_GPIO_A = 7;
  localparam int U_GPIO_E = 11;
  localparam int UNIT_SET [NUM_UNITS] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
  localparam int UNIT_BIT [NUM_UNITS] =
    '{0, 1, 4, 16, 17, 18, 24, 0, 1, 2, 3, 4};

  // System clock sources
  localparam int SRC_W = 2;
  localparam int DIV_W = 4;
  localparam logic [SRC_W-1:0] SRC_MAIN     = 2'h0;
  localparam logic [SRC_W-1:0] SRC_INTERNAL = 2'h1;
  localparam logic [DIV_W-1:0] DEEP_DIV     = 4'h0;

  typedef enum logic [1:0] {
    pwr_run,
    pwr_sleep,
    pwr_deep
  } power_e;

endpackage

/* clock_gate_cell.sv */
`timescale 1ns/1ps
// Latch-based cell: the enable can only change while the clock is low,
// so a change never chops a high phase short
module clock_gate_cell (
  input  wire logic clk_in,
  input  wire logic enable,
  output wire logic clk_out
);

  logic en_latch;

  always_latch begin
    if (!clk_in) begin
      en_latch <= enable;
    end
  end

  assign clk_out = clk_in & en_latch;

endmodule

/* peripheral_clock_gating.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module peripheral_clock_gating
  import clk_gate_pkg::*;
(
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic [clk_gate_pkg::ADDR_W-1:0]       addr,
  input  wire logic [clk_gate_pkg::DATA_W-1:0]       wdata,
  input  wire logic                                  wr,
  input  wire logic                                  rd,
  output logic      [clk_gate_pkg::DATA_W-1:0]       rdata,
  input  wire logic                                  auto_clock_gating,
  input  wire logic                                  sleep_now,
  input  wire logic                                  sleep_deep,
  input  wire logic                                  wake_event,
  input  wire logic [clk_gate_pkg::SRC_W-1:0]        run_clk_source,
  input  wire logic [clk_gate_pkg::DIV_W-1:0]        run_clk_div,
  input  wire logic                                  periph_access,
  input  wire logic [clk_gate_pkg::UNIT_IDX_W-1:0]   periph_index,
  output logic                                       bus_fault,
  output logic      [clk_gate_pkg::NUM_UNITS-1:0]    periph_clk_en,
  output wire logic [clk_gate_pkg::NUM_UNITS-1:0]    periph_clk,
  output logic      [clk_gate_pkg::SRC_W-1:0]        sys_clk_source,
  output logic      [clk_gate_pkg::DIV_W-1:0]        sys_clk_div,
  output logic                                       main_osc_en,
  output logic                                       internal_osc_en,
  input  wire logic                                  clk_fault,
  output logic                                       clk_fault_active,
  input  wire logic                                  ldo_unregulated,
  output logic                                       device_reset_req
);

  import clk_gate_pkg::*;

  // Register file
  logic [DATA_W-1:0] gate      [NUM_GATE];
  logic [DATA_W-1:0] next_gate [NUM_GATE];
  logic              internal_osc_override;
  logic              next_internal_osc_override;
  logic              verification_clear_bit;
  logic              next_verification_clear_bit;
  logic              regulator_reset_allow;
  logic              next_regulator_reset_allow;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    for (int i = 0; i < NUM_GATE; i++) begin
      next_gate[i] = gate[i];
    end
    next_internal_osc_override = internal_osc_override;
    next_verification_clear_bit = verification_clear_bit;
    next_regulator_reset_allow = regulator_reset_allow;
    if (wr) begin
      for (int i = 0; i < NUM_GATE; i++) begin
        if (addr == GATE_OFF[i]) begin
          // Reserved positions are not stored, so they read back as zero
          next_gate[i] = wdata & GATE_MASK[i];
        end
      end
      if (addr == OFF_DSLP) begin
        next_internal_osc_override = wdata[BIT_OSC_OVR];
      end
      if (addr == OFF_FAULT) begin
        next_verification_clear_bit = wdata[BIT_FAULT_CLR];
      end
      if (addr == OFF_LDO) begin
        next_regulator_reset_allow = wdata[BIT_LDO];
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    if (rd) begin
      for (int i = 0; i < NUM_GATE; i++) begin
        if (addr == GATE_OFF[i]) begin
          next_rdata = gate[i];
        end
      end
      if (addr == OFF_DSLP) begin
        next_rdata[BIT_OSC_OVR] = internal_osc_override;
      end
      if (addr == OFF_FAULT) begin
        next_rdata[BIT_FAULT_CLR] = verification_clear_bit;
      end
      if (addr == OFF_LDO) begin
        next_rdata[BIT_LDO] = regulator_reset_allow;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_GATE; i++) begin
        gate[i] <= GATE_RESET;
      end
      internal_osc_override <= 1'b0;
      verification_clear_bit <= 1'b0;
      regulator_reset_allow <= 1'b0;
      rdata <= '0;
    end else begin
      for (int i = 0; i < NUM_GATE; i++) begin
        gate[i] <= next_gate[i];
      end
      internal_osc_override <= next_internal_osc_override;
      verification_clear_bit <= next_verification_clear_bit;
      regulator_reset_allow <= next_regulator_reset_allow;
      rdata <= next_rdata;
    end
  end

  // Power mode and deep-sleep clock switching
  power_e            power_state;
  power_e            next_power_state;
  logic [SRC_W-1:0]  saved_src;
  logic [SRC_W-1:0]  next_saved_src;
  logic [DIV_W-1:0]  saved_div;
  logic [DIV_W-1:0]  next_saved_div;
  logic [SRC_W-1:0]  next_sys_clk_source;
  logic [DIV_W-1:0]  next_sys_clk_div;
  logic              next_main_osc_en;
  logic              next_internal_osc_en;
  logic              next_clk_fault_active;
  logic              next_device_reset_req;

  always_comb begin
    next_power_state = power_state;
    next_saved_src = saved_src;
    next_saved_div = saved_div;
    unique case (power_state)
      pwr_run: begin
        if (sleep_now) begin
          if (sleep_deep) begin
            next_power_state = pwr_deep;
            next_saved_src = run_clk_source;
            next_saved_div = run_clk_div;
          end else begin
            next_power_state = pwr_sleep;
          end
        end
      end
      pwr_sleep: begin
        if (wake_event) begin
          next_power_state = pwr_run;
        end
      end
      pwr_deep: begin
        if (wake_event) begin
          next_power_state = pwr_run;
        end
      end
    endcase
  end

  always_comb begin
    // Set wins: a fault in the clearing cycle stays flagged
    next_clk_fault_active = clk_fault_active;
    if (verification_clear_bit && !next_verification_clear_bit) begin
      next_clk_fault_active = 1'b0;
    end
    if (clk_fault) begin
      next_clk_fault_active = 1'b1;
    end
    next_device_reset_req = regulator_reset_allow && ldo_unregulated;
  end

  always_comb begin
    next_sys_clk_source = run_clk_source;
    next_sys_clk_div = run_clk_div;
    next_main_osc_en = 1'b1;
    next_internal_osc_en = (run_clk_source == SRC_INTERNAL);
    if (next_power_state == pwr_deep) begin
      next_sys_clk_source = next_saved_src;
      next_sys_clk_div = next_saved_div;
      if (internal_osc_override) begin
        next_sys_clk_source = SRC_INTERNAL;
        next_sys_clk_div = DEEP_DIV;
        next_main_osc_en = 1'b0;
        next_internal_osc_en = 1'b1;
      end
    end else if (power_state == pwr_deep) begin
      // Exit cycle uses the snapshot, not whatever the config shows now
      next_sys_clk_source = saved_src;
      next_sys_clk_div = saved_div;
      next_internal_osc_en = (saved_src == SRC_INTERNAL);
    end
    if (next_clk_fault_active) begin
      next_sys_clk_source = SRC_INTERNAL;
      next_internal_osc_en = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      power_state <= pwr_run;
      saved_src <= SRC_MAIN;
      saved_div <= '0;
      sys_clk_source <= SRC_MAIN;
      sys_clk_div <= '0;
      main_osc_en <= 1'b1;
      internal_osc_en <= 1'b0;
      clk_fault_active <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      power_state <= next_power_state;
      saved_src <= next_saved_src;
      saved_div <= next_saved_div;
      sys_clk_source <= next_sys_clk_source;
      sys_clk_div <= next_sys_clk_div;
      main_osc_en <= next_main_osc_en;
      internal_osc_en <= next_internal_osc_en;
      clk_fault_active <= next_clk_fault_active;
      device_reset_req <= next_device_reset_req;
    end
  end

  // Per-unit enable selection and gating cells
  logic [NUM_UNITS-1:0] run_en;
  logic [NUM_UNITS-1:0] sleep_en;
  logic [NUM_UNITS-1:0] deep_en;
  logic [NUM_UNITS-1:0] next_periph_clk_en;
  logic                 next_bus_fault;

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      assign run_en[u] =
        gate[GATE_RUN1 + UNIT_SET[u]][UNIT_BIT[u]];
      assign sleep_en[u] = gate[GATE_SLEEP1 + UNIT_SET[u]][UNIT_BIT[u]];
      assign deep_en[u] = gate[GATE_DEEP1 + UNIT_SET[u]][UNIT_BIT[u]];
      clock_gate_cell u_cell (
        .clk_in  (mclk),
        .enable  (periph_clk_en[u]),
        .clk_out (periph_clk[u])
      );
    end
  endgenerate

  always_comb begin
    next_periph_clk_en = run_en;
    if (auto_clock_gating) begin
      unique case (power_state)
        pwr_run:   next_periph_clk_en = run_en;
        pwr_sleep: next_periph_clk_en = sleep_en;
        pwr_deep:  next_periph_clk_en = deep_en;
      endcase
    end
    // Indices past the last unit are ungated and never fault
    next_bus_fault = 1'b0;
    if (periph_access && (periph_index < UNIT_IDX_W'(NUM_UNITS))) begin
      next_bus_fault = !periph_clk_en[periph_index];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      periph_clk_en <= '0;
      bus_fault <= 1'b0;
    end else begin
      periph_clk_en <= next_periph_clk_en;
      bus_fault <= next_bus_fault;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_deep_entry;
    power_state == pwr_run && sleep_now && sleep_deep && !clk_fault
      && !clk_fault_active;
  endsequence

  sequence s_deep_exit;
    power_state == pwr_deep && wake_event && !clk_fault && !clk_fault_active;
  endsequence

  sequence s_run_write(logic [ADDR_W-1:0] off);
    wr && addr == off && power_state == pwr_run && !sleep_now;
  endsequence

  AST_RESET_OFF: assert property (
    $past(rst) |-> periph_clk_en == '0 && !bus_fault)
    else $error("enables not zero after reset");
  AST_FAULT_ON_GATED: assert property (
    periph_access && periph_index < UNIT_IDX_W'(NUM_UNITS)
      |=> bus_fault == !$past(periph_clk_en[periph_index]))
    else $error("bus fault does not match unit enable");
  AST_ACG_OFF_RUN_SET: assert property (
    !auto_clock_gating |=> periph_clk_en == $past(run_en))
    else $error("run set not applied without auto gating");
  AST_SLEEP_SET: assert property (
    auto_clock_gating && power_state == pwr_sleep
      |=> periph_clk_en == $past(sleep_en))
    else $error("sleep set not applied in sleep");
  AST_COMPARATOR_ZERO_GATE_BIT: assert property (
    s_run_write(OFF_RUN1)
      |-> ##2 periph_clk_en[U_COMPARATOR0] == $past(wdata[24], 2))
    else $error("comparator enable not bit 24");
  AST_TIMER_BITS: assert property (
    s_run_write(OFF_RUN1)
      |-> ##2 periph_clk_en[U_TIMER2:U_TIMER0] == $past(wdata[18:16], 2))
    else $error("timer enables not bits 18 to 16");
  AST_SERIAL_BITS: assert property (
    s_run_write(OFF_RUN1)
      |-> ##2 periph_clk_en[U_SYNC_SERIAL] == $past(wdata[4], 2)
        && periph_clk_en[U_SERIAL1:U_SERIAL0] == $past(wdata[1:0], 2))
    else $error("serial enables on wrong bits");
  AST_GPIO_BITS: assert property (
    s_run_write(OFF_RUN2)
      |-> ##2 periph_clk_en[U_GPIO_E:U_GPIO_A] == $past(wdata[4:0], 2))
    else $error("gpio enables not bits 4 to 0");
  AST_OVERRIDE_ENTRY: assert property (
    s_deep_entry and internal_osc_override
      |=> sys_clk_source == SRC_INTERNAL && !main_osc_en && internal_osc_en)
    else $error("override did not switch to internal oscillator");
  AST_NO_OVERRIDE: assert property (
    s_deep_entry and !internal_osc_override
      |=> main_osc_en && sys_clk_source == $past(run_clk_source))
    else $error("main oscillator left in deep sleep");
  AST_EXIT_RESTORE: assert property (
    s_deep_exit |=> sys_clk_source == $past(saved_src)
      && sys_clk_div == $past(saved_div) && power_state == pwr_run)
    else $error("clock not restored on deep-sleep exit");
  AST_FAULT_CLOCK: assert property (
    clk_fault |=> clk_fault_active && sys_clk_source == SRC_INTERNAL)
    else $error("no substitute clock during fault");
  AST_FAULT_CLEAR: assert property (
    verification_clear_bit && wr && addr == OFF_FAULT
      && !wdata[BIT_FAULT_CLR] && !clk_fault |=> !clk_fault_active)
    else $error("fault not cleared by one then zero");
  AST_CLEAR_HOLDS: assert property (
    !(wr && addr == OFF_FAULT) |=> $stable(verification_clear_bit))
    else $error("clear bit changed on its own");
  AST_LDO_RESET: assert property (
    ldo_unregulated && regulator_reset_allow |=> device_reset_req)
    else $error("no reset on lost regulation");
  AST_LDO_BLOCKED: assert property (
    !regulator_reset_allow |=> !device_reset_req)
    else $error("reset raised while not allowed");

endmodule

/* periph_unit_model.sv */
`timescale 1ns/1ps
// Stand-in for one gated unit: it only counts the clock edges it gets,
// so a unit left unclocked shows up as a count that stands still
module periph_unit_model (
  input  wire logic clk_gated,
  output int        ticks
);
  int n = 0;

  assign ticks = n;

  always @(posedge clk_gated) begin
    n <= n + 1;
  end
endmodule

/* peripheral_clock_gating_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module peripheral_clock_gating_test;
  import clk_gate_pkg::*;
  localparam logic [ADDR_W-1:0] CTL_OFF [4] =
    '{OFF_DSLP, OFF_FAULT, OFF_LDO, 12'h200};
  logic                  mclk = 1'b0, rst = 1'b1;
  logic                  wr = 1'b0, rd = 1'b0, wake_event = 1'b0;
  logic                  auto_clock_gating = 1'b0, sleep_now = 1'b0;
  logic                  sleep_deep = 1'b0, periph_access = 1'b0;
  logic                  clk_fault = 1'b0, ldo_unregulated = 1'b0;
  logic                  bus_fault, main_osc_en, internal_osc_en;
  logic                  clk_fault_active, device_reset_req;
  logic [ADDR_W-1:0]     addr = '0;
  logic [DATA_W-1:0]     wdata = '0, rdata, v;
  logic [SRC_W-1:0]      run_clk_source = '0, sys_clk_source, src_s;
  logic [DIV_W-1:0]      run_clk_div = '0, sys_clk_div, div_s;
  logic [UNIT_IDX_W-1:0] periph_index = '0;
  logic [NUM_UNITS-1:0]  periph_clk_en, periph_clk, en;
  logic [DATA_W-1:0]     mdl_gate [NUM_GATE];
  int                    ticks [NUM_UNITS];
  int                    t0 [NUM_UNITS];
  int                    n_mismatch = 0, check_count = 0;

  always #20 mclk = ~mclk;

  peripheral_clock_gating i_dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .auto_clock_gating(auto_clock_gating),
    .sleep_now(sleep_now), .sleep_deep(sleep_deep),
    .wake_event(wake_event), .run_clk_source(run_clk_source),
    .run_clk_div(run_clk_div), .periph_access(periph_access),
    .periph_index(periph_index), .bus_fault(bus_fault),
    .periph_clk_en(periph_clk_en), .periph_clk(periph_clk),
    .sys_clk_source(sys_clk_source), .sys_clk_div(sys_clk_div),
    .main_osc_en(main_osc_en), .internal_osc_en(internal_osc_en),
    .clk_fault(clk_fault), .clk_fault_active(clk_fault_active),
    .ldo_unregulated(ldo_unregulated),
    .device_reset_req(device_reset_req)
  );

  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    periph_unit_model i_unit (.clk_gated(periph_clk[g]), .ticks(ticks[g]));
  end

  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [NUM_UNITS-1:0] exp_en(input int m);
    logic [NUM_UNITS-1:0] e;
    for (int u = 0; u < NUM_UNITS; u++) begin
      e[u] = mdl_gate[2 * m + UNIT_SET[u]][UNIT_BIT[u]];
    end
    return e;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    results();
  end

  initial begin
    void'($urandom(32'h39819b35));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_GATE; i++) begin
      rd_reg(GATE_OFF[i], v);
      `CHK(v, GATE_RESET)
    end
    for (int i = 0; i < 4; i++) begin
      rd_reg(CTL_OFF[i], v);
      `CHK(v, 32'h0)
    end
    `CHK(periph_clk_en, 12'h000)
    $display("test reset done");

    // Reserved positions are kept clear by software
    for (int i = 0; i < NUM_GATE; i++) begin
      mdl_gate[i] = $urandom & GATE_MASK[i];
      wr_reg(GATE_OFF[i], mdl_gate[i]);
    end
    for (int i = 0; i < NUM_GATE; i++) begin
      rd_reg(GATE_OFF[i], v);
      `CHK(v, mdl_gate[i])
    end
    $display("test registers done");

    en = exp_en(0);
    `CHK(periph_clk_en, en)
    for (int u = 0; u <= NUM_UNITS; u++) begin
      @(posedge mclk);
      periph_access <= 1'b1;
      periph_index <= UNIT_IDX_W'(u);
      @(posedge mclk);
      periph_access <= 1'b0;
      #1;
      `CHK(bus_fault, u < NUM_UNITS ? !en[u] : 1'b0)
    end
    t0 = ticks;
    repeat (8) @(posedge mclk);
    #1;
    for (int u = 0; u < NUM_UNITS; u++) begin
      `CHK(ticks[u] - t0[u], en[u] ? 8 : 0)
    end
    $display("test gating done");

    for (int k = 0; k < 8; k++) begin
      wr_reg(OFF_DSLP, DATA_W'(k[2]));
      @(posedge mclk);
      src_s = k[2] ? SRC_W'($urandom_range(1)) : SRC_MAIN;
      div_s = DIV_W'($urandom);
      run_clk_source <= src_s;
      run_clk_div <= div_s;
      auto_clock_gating <= k[0];
      sleep_deep <= k[1];
      sleep_now <= 1'b1;
      @(posedge mclk);
      sleep_now <= 1'b0;
      // A moving run clock proves the exit value is the saved one
      if (k >= 6) begin
        run_clk_source <= ~src_s;
        run_clk_div <= ~div_s;
      end
      repeat (2) @(posedge mclk);
      #1;
      `CHK(periph_clk_en, exp_en(k[0] ? 1 + k[1] : 0))
      if (k[1]) begin
        `CHK(sys_clk_source, k[2] ? SRC_INTERNAL : SRC_MAIN)
        `CHK(main_osc_en, !k[2])
        `CHK(internal_osc_en, k[2])
      end
      if (k >= 6) begin
        `CHK(sys_clk_div, DEEP_DIV)
      end
      @(posedge mclk);
      wake_event <= 1'b1;
      @(posedge mclk);
      wake_event <= 1'b0;
      #1;
      if (k[1]) begin
        `CHK({sys_clk_source, sys_clk_div}, {src_s, div_s})
        `CHK(main_osc_en, 1'b1)
      end
      repeat (2) @(posedge mclk);
      #1;
      `CHK(periph_clk_en, exp_en(0))
    end
    $display("test power modes done");

    @(posedge mclk);
    run_clk_source <= SRC_MAIN;
    clk_fault <= 1'b1;
    @(posedge mclk);
    clk_fault <= 1'b0;
    #1;
    `CHK({clk_fault_active, sys_clk_source}, {1'b1, SRC_INTERNAL})
    wr_reg(OFF_FAULT, 32'h1);
    repeat (3) @(posedge mclk);
    rd_reg(OFF_FAULT, v);
    `CHK({v, clk_fault_active}, {32'h1, 1'b1})
    wr_reg(OFF_FAULT, 32'h0);
    #1;
    `CHK(clk_fault_active, 1'b0)
    $display("test fault clear done");

    for (int k = 0; k < 4; k++) begin
      wr_reg(OFF_LDO, DATA_W'(k[1]));
      ldo_unregulated <= k[0];
      repeat (2) @(posedge mclk);
      #1;
      `CHK(device_reset_req, k[0] & k[1])
    end
    @(posedge mclk);
    ldo_unregulated <= 1'b0;
    $display("test regulator done");
    results();
  end
endmodule
